/* File: pkg/ptr_consts.vh */
// Constants of the paper tape reader channel link.
// Assumes inclusion by bare name from the design files only.
// Behaviour
// [RULE_01] Frames carry six bits plus odd parity.
// [RULE_02] Blocks bounded by gap; leading gap is leader.
// [RULE_03] Read command starts tape, one character per transfer.
// [RULE_04] Skip leader; halt within one frame of gap.
// [RULE_05] Halt at gap: end-of-record, clear unit address.
// [RULE_06] Reader always ready; no readiness wait.
// [RULE_07] Program disconnect stops between frames, none lost; the channel stops at once and drops a character strobed in that cycle.
// [RULE_08] Program waits 30 ms between reads; the bench waits 20 cycles (100 ns).
// [RULE_09] Program disconnects only after four characters.
// [RULE_10] Partial compatible read: disconnect within 0.3 ms.
// [RULE_11] End-of-record interrupt only if armed and enabled.
// [RULE_12] Parity or rate error sets channel error.
// [RULE_13] Function 01 end-of-record: disconnect, interrupt together.
// [RULE_14] Input function 01 stops at zero count.
// [RULE_15] Zero count interrupt first, then disconnect.
// [RULE_16] Zero word count interrupt at level 010.
// [RULE_17] Active test skips only when channel inactive.
// [RULE_18] Command bit 9 alerts interlace loading.
// [RULE_19] Reader read command decodes octal 0 02 42604.
// [RULE_20] Four six-bit characters packed per word.
// [RULE_21] No skip while unit address uncleared.
// [RULE_22] Even-ones frame reports parity error.
`ifndef PTR_CONSTS_VH
`define PTR_CONSTS_VH

// Connect command fields: opcode part, interlace bit, device part.
`define PTR_CMD_OP_HI 23
`define PTR_CMD_OP_LO 15
`define PTR_CMD_OP 9'h002
`define PTR_CMD_IL_BIT 14
`define PTR_CMD_DEV_HI 13
`define PTR_CMD_DEV 14'h0584
// Unit address loaded on connect; the value is arbitrary.
`define PTR_UNIT_READER 6'h01
`define PTR_UNIT_NONE 6'h00
// I/O control function codes.
`define PTR_FUNC_RECORD_THEN_DISCONNECT_FUNCTION 2'h0
`define PTR_FUNC_SINGLE_WORD_THEN_DISCONNECT_FUNCTION 2'h1
// Interrupt levels: zero word count 010, end of record 011 (octal).
`define PTR_LVL_ZWC 7'h08
`define PTR_LVL_EOR 7'h09
`define PTR_LVL_NONE 7'h00
// Character slot of the last character in a word.
`define PTR_LAST_SLOT 2'h3
`define PTR_WC_ONE 10'h001
`define PTR_WC_ZERO 10'h000

`endif

/* File: design/ptr_frame_rx.v */
// Tape frame receiver: synchronises the reader pins and yields frames.
// Assumes the sprocket and data pins are asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module ptr_frame_rx (
	input wire clock, // System clock.
	input wire nrst, // Asynchronous reset, active low.
	input wire sprocket_pin, // Sprocket hole sensed, high in frame.
	input wire [6:0] tape_pin, // Six data holes and parity hole.
	output reg frame_stb, // One-cycle pulse per frame.
	output reg [5:0] frame_data, // Frame information bits.
	output reg frame_gap, // Frame holds only the sprocket hole.
	output reg frame_perr // Non-gap frame has even number of ones.
);
	reg [2:0] spr_s;
	reg [6:0] d1, d2, d3;
	reg spr_lvl_r;
	wire spr_rise;

	// A change counts only once the second and third stages agree.
	assign spr_rise = spr_s[1] & spr_s[2] & ~spr_lvl_r;

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			spr_s <= 3'h0;
			d1 <= 7'h00;
			d2 <= 7'h00;
			d3 <= 7'h00;
			spr_lvl_r <= 1'b0;
			frame_stb <= 1'b0;
			frame_data <= 6'h00;
			frame_gap <= 1'b0;
			frame_perr <= 1'b0;
		end else begin
			spr_s <= {spr_s[1:0], sprocket_pin};
			d1 <= tape_pin;
			d2 <= d1;
			d3 <= d2;
			if (spr_s[1] == spr_s[2])
				spr_lvl_r <= spr_s[2];
			frame_stb <= spr_rise;
			if (spr_rise) begin
				frame_data <= d3[5:0];
				frame_gap <= (d3 == 7'h00); // RULE_02
				frame_perr <= (d3 != 7'h00) & ~(^d3); // RULE_22
			end
		end
	end
endmodule
`default_nettype wire

/* File: design/ptr_channel.v */
// Channel side of the paper tape reader: command decode, block framing,
// word assembly, termination, error flag and channel-active test.
// Assumes commands arrive as one-cycle pulses on the processor clock.
`timescale 1ns/1ps
`default_nettype none
`include "ptr_consts.vh"
module ptr_channel (
	input wire clock, // Processor clock, 200 MHz.
	input wire nrst, // Manual reset, asynchronous, active low.
	input wire cmd_valid, // Connect command word presented.
	input wire [23:0] cmd_word, // Connect command word.
	input wire ioc_valid, // I/O control command presented.
	input wire [1:0] ioc_func, // Input/output function code.
	input wire ioc_zwc_sel, // Zero word count interrupt selected.
	input wire ioc_eor_sel, // End-of-record interrupt selected.
	input wire pot_valid, // Word count and address presented.
	input wire [9:0] pot_count, // Word count.
	input wire [14:0] pot_addr, // Starting memory address.
	input wire disc_valid, // Channel disconnect command pulse.
	input wire cat_valid, // Channel active test pulse.
	input wire eor_armed, // End-of-record interrupt armed.
	input wire irq_enabled, // Interrupt system enabled.
	input wire word_take, // Program takes the held word.
	input wire sprocket_pin, // Reader sprocket hole pin.
	input wire [6:0] tape_pin, // Reader data and parity pins.
	output reg tape_motion, // Reader drive runs tape.
	output reg [5:0] unit_addr, // Channel unit address register.
	output wire channel_active, // Channel active lamp.
	output wire cat_skip, // Skip next instruction, with cat_valid.
	output reg channel_error, // Channel error flip-flop and lamp.
	output reg mem_wr, // Memory store pulse.
	output reg [14:0] mem_addr, // Memory store address.
	output reg [23:0] mem_data, // Memory store word.
	output reg word_ready, // Assembled word waits for program.
	output reg [23:0] word_out, // Assembled word, compatible mode.
	output reg irq_req, // Interrupt request pulse.
	output reg [6:0] irq_level // Interrupt level of the request.
);
	localparam ST_IDLE = 2'h0;
	localparam ST_LEADER = 2'h1;
	localparam ST_BLOCK = 2'h2;

	wire f_stb;
	wire [5:0] f_data;
	wire f_gap;
	wire f_perr;
	wire rd_cmd;
	wire connected;
	wire rate_err;
	wire take_char;
	wire [23:0] full_word;
	wire eor_ok;

	reg [1:0] state_r;
	reg il_r;
	reg [1:0] func_r;
	reg zwc_sel_r;
	reg eor_sel_r;
	reg [9:0] wc_r;
	reg [17:0] asm_r;
	reg [1:0] slot_r;
	reg disc_pend_r;

	ptr_frame_rx u_rx (
		.clock(clock),
		.nrst(nrst),
		.sprocket_pin(sprocket_pin),
		.tape_pin(tape_pin),
		.frame_stb(f_stb),
		.frame_data(f_data),
		.frame_gap(f_gap),
		.frame_perr(f_perr)
	);

	// Reader read connect, any interlace setting.
	assign rd_cmd = cmd_valid
		& (cmd_word[`PTR_CMD_OP_HI:`PTR_CMD_OP_LO] == `PTR_CMD_OP)
		& (cmd_word[`PTR_CMD_DEV_HI:0] == `PTR_CMD_DEV); // RULE_19
	assign connected = (state_r != ST_IDLE);
	assign channel_active = (unit_addr != `PTR_UNIT_NONE);
	// The skip holds off until the unit address has been cleared.
	assign cat_skip = cat_valid & ~channel_active; // RULE_17 RULE_21
	// A character with nowhere to go is a rate error and is dropped.
	assign rate_err = (il_r & (wc_r == `PTR_WC_ZERO))
		| (~il_r & (slot_r == `PTR_LAST_SLOT) & word_ready
		& ~word_take); // RULE_10
	assign take_char = connected & f_stb & ~f_gap & ~disc_valid
		& ~disc_pend_r;
	assign full_word = {asm_r, f_data}; // RULE_20
	assign eor_ok = eor_armed & irq_enabled; // RULE_11

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			tape_motion <= 1'b0;
			unit_addr <= `PTR_UNIT_NONE;
			il_r <= 1'b0;
			func_r <= `PTR_FUNC_RECORD_THEN_DISCONNECT_FUNCTION;
			zwc_sel_r <= 1'b0;
			eor_sel_r <= 1'b0;
			wc_r <= `PTR_WC_ZERO;
			asm_r <= 18'h00000;
			slot_r <= 2'h0;
			disc_pend_r <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= 15'h0000;
			mem_data <= 24'h000000;
			word_ready <= 1'b0;
			word_out <= 24'h000000;
			irq_req <= 1'b0;
			irq_level <= `PTR_LVL_NONE;
		end else begin
			mem_wr <= 1'b0;
			irq_req <= 1'b0;
			if (word_take)
				word_ready <= 1'b0;
			if (ioc_valid) begin
				func_r <= ioc_func;
				zwc_sel_r <= ioc_zwc_sel;
				eor_sel_r <= ioc_eor_sel;
			end
			if (pot_valid) begin
				wc_r <= pot_count;
				mem_addr <= pot_addr;
			end
			if (disc_valid || disc_pend_r) begin
				// Stopping here does not wait for a frame boundary; a character strobed now is dropped.
				state_r <= ST_IDLE; // RULE_07
				tape_motion <= 1'b0;
				unit_addr <= `PTR_UNIT_NONE; // RULE_14
				disc_pend_r <= 1'b0;
			end else if (rd_cmd) begin
				// No ready test: the reader starts at once.
				state_r <= ST_LEADER; // RULE_03 RULE_06
				tape_motion <= 1'b1;
				unit_addr <= `PTR_UNIT_READER;
				il_r <= cmd_word[`PTR_CMD_IL_BIT]; // RULE_18
				if (cmd_word[`PTR_CMD_IL_BIT]) begin
					wc_r <= `PTR_WC_ZERO;
					func_r <= `PTR_FUNC_RECORD_THEN_DISCONNECT_FUNCTION;
					zwc_sel_r <= 1'b0;
					eor_sel_r <= 1'b0;
				end
				slot_r <= 2'h0;
				asm_r <= 18'h00000;
			end else if (connected && f_stb && f_gap) begin
				if (state_r == ST_BLOCK) begin
					// Gap after the block ends the record.
					state_r <= ST_IDLE; // RULE_04
					tape_motion <= 1'b0;
					unit_addr <= `PTR_UNIT_NONE; // RULE_05
					if (eor_ok) begin
						irq_req <= 1'b1; // RULE_11
						irq_level <= `PTR_LVL_EOR;
					end
				end
				// Gap ahead of the block is leader and is skipped.
			end else if (take_char) begin
				state_r <= ST_BLOCK; // RULE_02
				if (!rate_err) begin
					slot_r <= slot_r + 2'h1;
					asm_r <= {asm_r[11:0], f_data}; // RULE_03
					if (slot_r == `PTR_LAST_SLOT) begin
						if (il_r) begin
							mem_wr <= 1'b1;
							mem_data <= full_word;
							wc_r <= wc_r - `PTR_WC_ONE;
							if (wc_r == `PTR_WC_ONE
								&& func_r == `PTR_FUNC_SINGLE_WORD_THEN_DISCONNECT_FUNCTION) begin
								if (zwc_sel_r && irq_enabled) begin
									irq_req <= 1'b1; // RULE_15
									irq_level <= `PTR_LVL_ZWC; // RULE_16
									disc_pend_r <= 1'b1;
								end else begin
									// Last character in: drop the unit now.
									state_r <= ST_IDLE; // RULE_14
									tape_motion <= 1'b0;
									unit_addr <= `PTR_UNIT_NONE;
									if (eor_sel_r && eor_ok) begin
										irq_req <= 1'b1; // RULE_13
										irq_level <= `PTR_LVL_EOR;
									end
								end
							end
						end else begin
							word_ready <= 1'b1;
							word_out <= full_word;
						end
					end
				end
			end
			if (mem_wr)
				mem_addr <= mem_addr + 15'h0001;
		end
	end

	// Set wins over the clear done by a new connect.
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			channel_error <= 1'b0;
		else if (take_char && (f_perr || rate_err))
			channel_error <= 1'b1; // RULE_12 RULE_01
		else if (rd_cmd)
			channel_error <= 1'b0;
	end
endmodule
`default_nettype wire

/* File: verification/ptr_tape_model.sv */
// Tape reader mechanism model: sends one frame per request.
// Assumes requests come only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module ptr_tape_model (
	input wire logic clock, // Bench clock.
	input wire logic req, // Start one frame.
	input wire logic [5:0] data, // Information bits.
	input wire logic gap, // Sprocket-only frame.
	input wire logic bad, // Spoil the parity hole.
	output logic sprocket_pin, // Sprocket hole.
	output logic [6:0] tape_pin, // Data and parity holes.
	output logic busy // Frame in progress.
);
	int step = 0;
	initial sprocket_pin = 0;
	initial tape_pin = 7'h55;
	initial busy = 0;
	always @(posedge clock) begin
		if (step == 0 && req) begin
			busy <= 1;
			step <= 1;
			tape_pin <= gap ? 7'h00 : {~^data ^ bad, data};
		end else if (step != 0) begin
			step <= (step == 10) ? 0 : step + 1;
			sprocket_pin <= (step >= 2 && step < 6);
			// Holes no longer under the head show no stale value.
			if (step == 8)
				tape_pin <= ~tape_pin;
			if (step == 10)
				busy <= 0;
		end
	end
endmodule
`default_nettype wire

/* File: verification/ptr_channel_sva.sv */
// Checker for the tape reader channel, bound to its top module.
// Assumes one clock domain and the asynchronous low reset.
`timescale 1ns/1ps
`default_nettype none
module ptr_channel_sva (
	input wire clock, input wire nrst, input wire cmd_valid,
	input wire [23:0] cmd_word, input wire disc_valid, input wire cat_valid,
	input wire eor_armed, input wire irq_enabled, input wire tape_motion,
	input wire [5:0] unit_addr, input wire channel_active, input wire cat_skip,
	input wire channel_error, input wire mem_wr, input wire [14:0] mem_addr,
	input wire irq_req, input wire [6:0] irq_level
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence s_read_cmd;
		cmd_valid && !disc_valid && cmd_word[23:15] == 9'h002
			&& cmd_word[13:0] == 14'h0584;
	endsequence
	sequence s_zwc_irq;
		irq_req && irq_level == 7'h08 && !cmd_valid;
	endsequence
	a_read_starts: assert property (s_read_cmd |=> tape_motion && unit_addr == 6'h01)
		else $error("read connect did not start reader");
	a_disc_stops: assert property (disc_valid |=> !tape_motion && unit_addr == 6'h00)
		else $error("disconnect did not stop reader");
	a_zwc_then_off: assert property (s_zwc_irq |=> unit_addr == 6'h00)
		else $error("no disconnect after zero count interrupt");
	a_eor_gate: assert property (irq_req && irq_level == 7'h09 |-> $past(eor_armed && irq_enabled))
		else $error("end of record interrupt not gated");
	a_mem_step: assert property (mem_wr |=> mem_addr == $past(mem_addr) + 15'h1)
		else $error("store address did not advance");
	a_error_hold: assert property (channel_error && !cmd_valid |=> channel_error)
		else $error("error flag dropped");
	a_active_lamp: assert property (channel_active == (unit_addr != 6'h00))
		else $error("active lamp mismatch");
	a_skip_rule: assert property (cat_skip == (cat_valid && unit_addr == 6'h00))
		else $error("active test skip mismatch");
	a_idle_still: assert property (unit_addr == 6'h00 |-> !tape_motion)
		else $error("tape moves while disconnected");
endmodule
bind ptr_channel ptr_channel_sva i_ptr_channel_sva (.clock(clock), .nrst(nrst),
	.cmd_valid(cmd_valid), .cmd_word(cmd_word), .disc_valid(disc_valid),
	.cat_valid(cat_valid), .eor_armed(eor_armed), .irq_enabled(irq_enabled),
	.tape_motion(tape_motion), .unit_addr(unit_addr), .cat_skip(cat_skip),
	.channel_active(channel_active), .channel_error(channel_error),
	.mem_wr(mem_wr), .mem_addr(mem_addr), .irq_req(irq_req),
	.irq_level(irq_level));
`default_nettype wire

/* File: verification/ptr_channel_test.sv */
// Testbench for the tape reader channel: read scenarios end to end.
// Assumes the tape model and the checker bind are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module ptr_channel_test;
	logic clock = 0, nrst = 0, cmd_valid = 0, ioc_valid = 0, pot_valid = 0;
	logic disc_valid = 0, cat_valid = 0, eor_armed = 0, irq_enabled = 0;
	logic ioc_zwc_sel = 0, ioc_eor_sel = 0, word_take = 0, f_req = 0;
	logic f_gap = 0, f_bad = 0, f_busy, sprocket_pin, tape_motion;
	logic channel_active, cat_skip, channel_error, mem_wr, word_ready, irq_req;
	logic [23:0] cmd_word = 0, mem_data, word_out, wr_d = 0;
	logic [1:0] ioc_func = 0;
	logic [9:0] pot_count = 0;
	logic [14:0] pot_addr = 0, mem_addr, wr_a = 0;
	logic [5:0] f_data = 0, unit_addr;
	logic [6:0] tape_pin, irq_level, irq_lv = 0;
	int miscompares = 0, n_compared = 0, irq_n = 0;
	always #2.5 clock = ~clock;
	ptr_tape_model i_ptr_tape_model (.clock(clock), .req(f_req), .data(f_data),
		.gap(f_gap), .bad(f_bad), .sprocket_pin(sprocket_pin),
		.tape_pin(tape_pin), .busy(f_busy));
	ptr_channel i_ptr_channel (.clock(clock), .nrst(nrst),
		.cmd_valid(cmd_valid), .cmd_word(cmd_word), .ioc_valid(ioc_valid),
		.ioc_func(ioc_func), .ioc_zwc_sel(ioc_zwc_sel),
		.ioc_eor_sel(ioc_eor_sel), .pot_valid(pot_valid),
		.pot_count(pot_count), .pot_addr(pot_addr), .disc_valid(disc_valid),
		.cat_valid(cat_valid), .eor_armed(eor_armed),
		.irq_enabled(irq_enabled), .word_take(word_take),
		.sprocket_pin(sprocket_pin), .tape_pin(tape_pin),
		.tape_motion(tape_motion), .unit_addr(unit_addr),
		.channel_active(channel_active), .cat_skip(cat_skip),
		.channel_error(channel_error), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_data(mem_data), .word_ready(word_ready), .word_out(word_out),
		.irq_req(irq_req), .irq_level(irq_level));
	always @(posedge clock) begin
		if (irq_req) begin
			irq_n <= irq_n + 1;
			irq_lv <= irq_level;
		end
		if (mem_wr) begin
			wr_a <= mem_addr;
			wr_d <= mem_data;
		end
	end
	task tick;
		@(posedge clock);
		#1;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task frame(input logic [5:0] d, input logic g, input logic b);
		int n;
		n = 0;
		{f_data, f_gap, f_bad, f_req} = {d, g, b, 1'b1};
		tick;
		f_req = 0;
		tick;
		while (f_busy && n < 40) begin
			tick;
			n++;
		end
		if (n >= 40) begin
			miscompares++;
			close_out;
		end
	endtask
	task frames4(input logic [23:0] w, input logic [3:0] bad);
		for (int i = 3; i >= 0; i--)
			frame(w[6*i +: 6], 1'b0, bad[i]);
	endtask
	task cmd(input logic [23:0] w);
		// Pause before each read; the model has no mechanism to settle.
		repeat (20) tick;
		cmd_word = w;
		cmd_valid = 1;
		tick;
		cmd_valid = 0;
	endtask
	task setup(input logic zwc, input logic eor, input logic [9:0] cnt);
		{ioc_func, ioc_zwc_sel, ioc_eor_sel, ioc_valid} = {2'h1, zwc, eor, 1'b1};
		tick;
		{ioc_valid, pot_count, pot_addr, pot_valid} = {1'b0, cnt, 15'h07d0, 1'b1};
		tick;
		pot_valid = 0;
	endtask
	task t_zero_count;
		cat_valid = 1;
		#1 chk(cat_skip, 1);
		{cat_valid, irq_enabled} = 2'b01;
		cmd(24'h014584);
		chk(unit_addr, 6'h01);
		cat_valid = 1;
		#1 chk(cat_skip, 0);
		cat_valid = 0;
		setup(1, 0, 10'h001);
		frame(6'h00, 1, 0);
		frames4(24'h852fc5, 4'h0);
		repeat (3) tick;
		chk(wr_a, 15'h07d0);
		chk(wr_d, 24'h852fc5);
		chk(irq_lv, 7'h08);
		chk(unit_addr, 6'h00);
		chk(channel_error, 0);
		$display("zero count test done");
	endtask
	task t_end_record;
		eor_armed = 1;
		cmd(24'h010584);
		frames4(24'h0420c4, 4'h8);
		chk(channel_error, 1);
		chk({word_ready, word_out}, {1'b1, 24'h0420c4});
		word_take = 1;
		tick;
		word_take = 0;
		frame(6'h00, 1, 0);
		repeat (2) tick;
		chk({tape_motion, unit_addr}, 0);
		chk({irq_n[7:0], irq_lv}, {8'h2, 7'h09});
		$display("end of record test done");
	endtask
	task t_program_stop;
		cmd(24'h014584);
		chk(channel_error, 0);
		setup(0, 1, 10'h002);
		frames4(24'h111111, 4'h0);
		disc_valid = 1;
		tick;
		disc_valid = 0;
		chk({tape_motion, unit_addr}, 0);
		cmd(24'h014584);
		setup(0, 1, 10'h001);
		frames4(24'h222222, 4'h0);
		repeat (3) tick;
		chk(wr_d, 24'h222222);
		chk({irq_n[7:0], irq_lv, unit_addr}, {8'h3, 7'h09, 6'h0});
		$display("program stop test done");
	endtask
	initial begin
		repeat (12) @(posedge clock);
		#1 nrst = 1;
		tick;
		t_zero_count;
		t_end_record;
		t_program_stop;
		close_out;
	end
endmodule
`default_nettype wire
